// ---- hdl/sar_converter_sequencer.sv ----
// Sequencer and register file around a 12-bit successive-approximation
// converter. Assumes a byte-wide register port synchronous to clk and an
// analog sampler that answers each conversion with a done pulse and code.
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"

module sar_converter_sequencer #(
	parameter int unsigned CODE_W = 12
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Register port
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrRdEn,
	output logic [7:0] sfrRdData,
	// Convert-start sources
	input wire logic timer3Overflow,
	input wire logic timer2Overflow,
	input wire logic externalConvertPin,
	// Analog sampler
	input wire logic sampleDone,
	input wire logic [CODE_W-1:0] sampleCode,
	output logic analogPowerOn,
	output logic analogTrack,
	output logic analogConvert,
	output logic sarClockTick,
	// Event pulses
	output logic conversionDoneEvent,
	output logic windowMatchEvent
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	sar_pkg::sar_state_t state_q, state_d;
	sar_pkg::sar_ctrl_t ctrl_q, ctrl_d;
	sar_pkg::sar_cfg_t cfg_q, cfg_d;
	sar_pkg::sar_track_t trk_q, trk_d;
	logic [15:0] upper_q, upper_d, lower_q, lower_d;
	logic [15:0] result_q, result_d, acc_q, acc_d;
	logic [3:0] convCnt_q, convCnt_d;
	logic [4:0] divCnt_q, divCnt_d;
	logic [9:0] waitCnt_q, waitCnt_d;
	logic [4:0] sarCnt_q, sarCnt_d;
	logic [1:0] tailCnt_q, tailCnt_d;
	logic pinLast_q;
	logic [7:0] rd_q, rd_d;
	logic pwr_q, pwr_d, trk_o_q, trk_o_d, conv_q, conv_d, tick_q, tick_d;
	logic doneEv_q, doneEv_d, winEv_q, winEv_d;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	logic [3:0] lastIdx;
	logic [15:0] word, newWord, newSum;
	logic trigger, startOk, divTick, lastConv, match;
	logic wrCtrl;

	// Series length from repeat code
	always_comb begin
		case (cfg_q.repeatCount)
			`SAR_RPT_ONE: lastIdx = `SAR_LAST_ONE;
			`SAR_RPT_FOUR: lastIdx = `SAR_LAST_FOUR;
			`SAR_RPT_EIGHT: lastIdx = `SAR_LAST_EIGHT;
			default: lastIdx = `SAR_LAST_SIXTEEN;
		endcase
	end

	// Justified view of a raw sum
	function automatic logic [15:0] justify(input logic [15:0] s,
			input logic left);
		justify = left ? {s[11:0], 4'h0} : s;
	endfunction

	// Window test on a justified word
	function automatic logic inWindow(input logic [15:0] w,
			input logic [15:0] up, input logic [15:0] lo);
		if (lo > up) begin
			inWindow = (w > up) && (w < lo);
		end else begin
			inWindow = (w < lo) || (w > up);
		end
	endfunction

	// Trigger selection and start qualification
	always_comb begin
		wrCtrl = sfrWrEn && (sfrAddr == `SAR_OFS_CTRL);
		case (ctrl_q.startSource)
			`SAR_SRC_BUSY: trigger = wrCtrl && sfrWrData[4];
			`SAR_SRC_TIMER3: trigger = timer3Overflow;
			`SAR_SRC_PIN: trigger = externalConvertPin && !pinLast_q;
			default: trigger = timer2Overflow;
		endcase
		// Shutdown ignores starts unless burst wakes the converter
		startOk = trigger && (state_q == sar_pkg::SAR_IDLE) &&
			(ctrl_q.enable || ctrl_q.burst);
		// Base clock is clk in both modes
		divTick = (divCnt_q == cfg_q.clockDivider);
		word = justify(result_q, ctrl_q.leftJustify);
		newSum = acc_q + {{(16-CODE_W){1'b0}}, sampleCode};
		lastConv = (convCnt_q == lastIdx);
		newWord = justify(newSum, ctrl_q.leftJustify);
		match = inWindow(newWord, upper_q, lower_q);
	end

	// ----------------------------------------------------------------
	// Next state of sequencer and registers
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		ctrl_d = ctrl_q;
		cfg_d = cfg_q;
		trk_d = trk_q;
		upper_d = upper_q;
		lower_d = lower_q;
		result_d = result_q;
		acc_d = acc_q;
		convCnt_d = convCnt_q;
		waitCnt_d = waitCnt_q;
		sarCnt_d = sarCnt_q;
		tailCnt_d = tailCnt_q;
		doneEv_d = 1'b0;
		winEv_d = 1'b0;
		// Conversion clock divider, free running
		divCnt_d = divTick ? 5'h00 : divCnt_q + 5'h01;
		tick_d = divTick;

		// Software writes
		if (sfrWrEn) begin
			case (sfrAddr)
				`SAR_OFS_TRACK: trk_d = sfrWrData;
				`SAR_OFS_CFG: cfg_d = {sfrWrData[7:1], 1'b0};
				`SAR_OFS_RES_LO: begin
					result_d[7:0] = sfrWrData;
					acc_d[7:0] = sfrWrData;
				end
				`SAR_OFS_RES_HI: begin
					result_d[15:8] = sfrWrData;
					acc_d[15:8] = sfrWrData;
				end
				`SAR_OFS_UPPER_LO: upper_d[7:0] = sfrWrData;
				`SAR_OFS_UPPER_HI: upper_d[15:8] = sfrWrData;
				`SAR_OFS_LOWER_LO: lower_d[7:0] = sfrWrData;
				`SAR_OFS_LOWER_HI: lower_d[15:8] = sfrWrData;
				`SAR_OFS_CTRL: begin
					ctrl_d.enable = sfrWrData[7];
					ctrl_d.burst = sfrWrData[6];
					ctrl_d.doneFlag = sfrWrData[5];
					ctrl_d.windowFlag = sfrWrData[3];
					ctrl_d.leftJustify = sfrWrData[2];
					ctrl_d.startSource = sfrWrData[1:0];
				end
				default: ;
			endcase
		end

		// Sequencer
		case (state_q)
			sar_pkg::SAR_IDLE: begin
				if (startOk) begin
					if (ctrl_q.burst && !ctrl_q.enable) begin
						state_d = sar_pkg::SAR_PWRUP;
						waitCnt_d = 10'(({6'h00, trk_q.powerUpTime} + 10'h001) *
							10'(`SAR_PWR_STEP_CYC));
					end else if (!ctrl_q.burst &&
							trk_q.trackingMode == `SAR_TM_PRE) begin
						state_d = sar_pkg::SAR_CONV;
					end else begin
						state_d = sar_pkg::SAR_TRACK;
						sarCnt_d = `SAR_POST_BASE << trk_q.postTrackTime;
					end
				end
			end
			sar_pkg::SAR_PWRUP: begin
				waitCnt_d = waitCnt_q - 10'h001;
				if (waitCnt_q == 10'h001) begin
					state_d = sar_pkg::SAR_TRACK;
					sarCnt_d = `SAR_POST_BASE << trk_q.postTrackTime;
				end
			end
			sar_pkg::SAR_TRACK: begin
				// Count conversion clocks of post-tracking
				if (divTick) begin
					sarCnt_d = sarCnt_q - 5'h01;
					if (sarCnt_q == 5'h01) begin
						state_d = sar_pkg::SAR_TAIL;
						tailCnt_d = `SAR_TAIL_CYC;
					end
				end
			end
			sar_pkg::SAR_TAIL: begin
				// Two extra base-clock cycles
				tailCnt_d = tailCnt_q - 2'h1;
				if (tailCnt_q == 2'h1) begin
					state_d = sar_pkg::SAR_CONV;
				end
			end
			sar_pkg::SAR_CONV: begin
				if (sampleDone) begin
					acc_d = newSum;
					convCnt_d = convCnt_q + 4'h1;
					state_d = sar_pkg::SAR_IDLE;
					if (lastConv) begin
						result_d = newSum;
						acc_d = `SAR_RST_RESULT;
						convCnt_d = 4'h0;
						doneEv_d = 1'b1;
						winEv_d = match;
					end else if (ctrl_q.burst) begin
						// Burst self-times the rest of the series
						state_d = sar_pkg::SAR_TRACK;
						sarCnt_d = `SAR_POST_BASE << trk_q.postTrackTime;
					end
				end
			end
			default: state_d = sar_pkg::SAR_IDLE;
		endcase

		// Burst without enable is allowed to run; otherwise disable aborts
		if (!ctrl_d.enable && !ctrl_q.burst) begin
			state_d = sar_pkg::SAR_IDLE;
		end
		// Hardware set wins over a software clear
		if (doneEv_d) begin
			ctrl_d.doneFlag = 1'b1;
		end
		if (winEv_d) begin
			ctrl_d.windowFlag = 1'b1;
		end
		ctrl_d.busy = (state_d != sar_pkg::SAR_IDLE);

		// Outputs to the sampler
		pwr_d = ctrl_d.enable || (state_d != sar_pkg::SAR_IDLE);
		trk_o_d = (state_d == sar_pkg::SAR_TRACK) ||
			(state_d == sar_pkg::SAR_TAIL);
		conv_d = (state_d == sar_pkg::SAR_CONV);
	end

	// Read data, registered for one cycle of latency
	always_comb begin
		rd_d = rd_q;
		if (sfrRdEn) begin
			case (sfrAddr)
				`SAR_OFS_TRACK: rd_d = trk_q;
				`SAR_OFS_CFG: rd_d = {cfg_q[7:1], 1'b0};
				`SAR_OFS_RES_LO: rd_d = word[7:0];
				`SAR_OFS_RES_HI: rd_d = word[15:8];
				`SAR_OFS_UPPER_LO: rd_d = upper_q[7:0];
				`SAR_OFS_UPPER_HI: rd_d = upper_q[15:8];
				`SAR_OFS_LOWER_LO: rd_d = lower_q[7:0];
				`SAR_OFS_LOWER_HI: rd_d = lower_q[15:8];
				`SAR_OFS_CTRL: rd_d = ctrl_q;
				default: rd_d = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_q <= sar_pkg::SAR_IDLE;
			ctrl_q <= `SAR_RST_CTRL;
			cfg_q <= `SAR_RST_CFG;
			trk_q <= `SAR_RST_TRACK;
			upper_q <= `SAR_RST_UPPER;
			lower_q <= `SAR_RST_LOWER;
			result_q <= `SAR_RST_RESULT;
			acc_q <= `SAR_RST_RESULT;
			convCnt_q <= 4'h0;
			divCnt_q <= 5'h00;
			waitCnt_q <= 10'h000;
			sarCnt_q <= 5'h00;
			tailCnt_q <= 2'h0;
			pinLast_q <= 1'b0;
			rd_q <= 8'h00;
			pwr_q <= 1'b0;
			trk_o_q <= 1'b0;
			conv_q <= 1'b0;
			tick_q <= 1'b0;
			doneEv_q <= 1'b0;
			winEv_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			cfg_q <= cfg_d;
			trk_q <= trk_d;
			upper_q <= upper_d;
			lower_q <= lower_d;
			result_q <= result_d;
			acc_q <= acc_d;
			convCnt_q <= convCnt_d;
			divCnt_q <= divCnt_d;
			waitCnt_q <= waitCnt_d;
			sarCnt_q <= sarCnt_d;
			tailCnt_q <= tailCnt_d;
			pinLast_q <= externalConvertPin;
			rd_q <= rd_d;
			pwr_q <= pwr_d;
			trk_o_q <= trk_o_d;
			conv_q <= conv_d;
			tick_q <= tick_d;
			doneEv_q <= doneEv_d;
			winEv_q <= winEv_d;
		end
	end

	// Outputs straight from flops
	assign sfrRdData = rd_q;
	assign analogPowerOn = pwr_q;
	assign analogTrack = trk_o_q;
	assign analogConvert = conv_q;
	assign sarClockTick = tick_q;
	assign conversionDoneEvent = doneEv_q;
	assign windowMatchEvent = winEv_q;

endmodule

`default_nettype wire

// ---- hdl/sar_params.svh ----
// Register offsets, field codes, reset values and timing constants
// for the converter sequencer. Included by the top module, the checker and the bench.
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SAR_OFS_TRACK 8'hba
`define SAR_OFS_CFG 8'hbc
`define SAR_OFS_RES_LO 8'hbd
`define SAR_OFS_RES_HI 8'hbe
`define SAR_OFS_UPPER_LO 8'hc3
`define SAR_OFS_UPPER_HI 8'hc4
`define SAR_OFS_LOWER_LO 8'hc5
`define SAR_OFS_LOWER_HI 8'hc6
`define SAR_OFS_CTRL 8'he8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SAR_RST_TRACK 8'hff
`define SAR_RST_CFG 8'hf8
`define SAR_RST_CTRL 8'h00
`define SAR_RST_UPPER 16'hffff
`define SAR_RST_LOWER 16'h0000
`define SAR_RST_RESULT 16'h0000

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define SAR_SRC_BUSY 2'h0
`define SAR_SRC_TIMER3 2'h1
`define SAR_SRC_PIN 2'h2
`define SAR_SRC_TIMER2 2'h3
`define SAR_TM_PRE 2'h2
`define SAR_RPT_ONE 2'h0
`define SAR_RPT_FOUR 2'h1
`define SAR_RPT_EIGHT 2'h2
`define SAR_LAST_ONE 4'h0
`define SAR_LAST_FOUR 4'h3
`define SAR_LAST_EIGHT 4'h7
`define SAR_LAST_SIXTEEN 4'hf

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SAR_CLK_PERIOD_NS 10
`define SAR_PWR_STEP_NS 400
`define SAR_PWR_STEP_CYC ((`SAR_PWR_STEP_NS+`SAR_CLK_PERIOD_NS-1)/`SAR_CLK_PERIOD_NS)
`define SAR_TAIL_CYC 2'h2
`define SAR_POST_BASE 5'h02

`endif

// ---- hdl/sar_pkg.sv ----
// Types shared by the converter sequencer: state codes and register fields.
// Assumes nothing of its surroundings.
package sar_pkg;

	// Sequencer states, Gray coded along idle-power-track-tail-convert
	typedef enum logic [2:0] {
		SAR_IDLE = 3'h0,
		SAR_PWRUP = 3'h1,
		SAR_TRACK = 3'h3,
		SAR_TAIL = 3'h2,
		SAR_CONV = 3'h6
	} sar_state_t;

	// Control register fields, high bit first
	typedef struct packed {
		logic enable;
		logic burst;
		logic doneFlag;
		logic busy;
		logic windowFlag;
		logic leftJustify;
		logic [1:0] startSource;
	} sar_ctrl_t;

	// Configuration register fields
	typedef struct packed {
		logic [4:0] clockDivider;
		logic [1:0] repeatCount;
		logic reserved;
	} sar_cfg_t;

	// Tracking and power register fields
	typedef struct packed {
		logic [3:0] powerUpTime;
		logic [1:0] trackingMode;
		logic [1:0] postTrackTime;
	} sar_track_t;

endpackage

// ---- test/sar_checker.sv ----
// Port-level assertions for the converter sequencer.
// Assumes binding onto the top module, one clock; checks pause while ce low.
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"

module sar_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Register port
	input wire logic [7:0] sfrAddr,
	input wire logic sfrRdEn,
	input wire logic [7:0] sfrRdData,
	// Sampler and events
	input wire logic sampleDone,
	input wire logic analogPowerOn,
	input wire logic analogTrack,
	input wire logic analogConvert,
	input wire logic sarClockTick,
	input wire logic conversionDoneEvent,
	input wire logic windowMatchEvent
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst || !ce);
	property p_convHold;
		analogConvert && !sampleDone |=> analogConvert;
	endproperty
	a_convHold: assert property (p_convHold) else $error("convert dropped early");
	property p_convEnd;
		analogConvert && sampleDone |=> !analogConvert;
	endproperty
	a_convEnd: assert property (p_convEnd) else $error("convert held on");
	property p_doneCause;
		conversionDoneEvent |-> $past(sampleDone) && $past(analogConvert);
	endproperty
	a_doneCause: assert property (p_doneCause) else $error("done without end");
	property p_donePulse;
		conversionDoneEvent |=> !conversionDoneEvent;
	endproperty
	a_donePulse: assert property (p_donePulse) else $error("done too long");
	property p_winWithDone;
		windowMatchEvent |-> conversionDoneEvent;
	endproperty
	a_winWithDone: assert property (p_winWithDone) else $error("window alone");
	property p_phaseExcl;
		!(analogTrack && analogConvert);
	endproperty
	a_phaseExcl: assert property (p_phaseExcl) else $error("track and convert");
	property p_powered;
		analogTrack || analogConvert |-> analogPowerOn;
	endproperty
	a_powered: assert property (p_powered) else $error("work while off");
	property p_trackToConv;
		// Enable abort drops track and power together
		$fell(analogTrack) && analogPowerOn |-> analogConvert;
	endproperty
	a_trackToConv: assert property (p_trackToConv) else $error("no convert");
	property p_tick;
		sarClockTick |=> !sarClockTick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick too fast");
	property p_cfgBit0;
		sfrRdEn && sfrAddr == `SAR_OFS_CFG |=> !sfrRdData[0];
	endproperty
	a_cfgBit0: assert property (p_cfgBit0) else $error("cfg bit0 set");
	c_done: cover property (conversionDoneEvent);
	c_win: cover property (windowMatchEvent);
	c_wake: cover property (analogPowerOn && !analogTrack && !analogConvert);
endmodule

bind sar_converter_sequencer sar_checker chk_u (.clk(clk), .nrst(nrst),
	.ce(ce), .sfrAddr(sfrAddr), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
	.sampleDone(sampleDone), .analogPowerOn(analogPowerOn),
	.analogTrack(analogTrack), .analogConvert(analogConvert),
	.sarClockTick(sarClockTick), .conversionDoneEvent(conversionDoneEvent),
	.windowMatchEvent(windowMatchEvent));
`default_nettype wire

// ---- test/sar_sampler.sv ----
// Behavioural analog sampler for the sequencer bench.
// Assumes analogConvert from the design; answers after delayIn cycles.
`timescale 1ns/1ps
`default_nettype none

module sar_sampler (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Design side
	input wire logic analogConvert,
	output logic sampleDone,
	output logic [11:0] sampleCode,
	// Bench control
	input wire logic [3:0] delayIn,
	input wire logic [11:0] codeIn
);
	// ----------------------------------------------------------------
	// One answer per conversion, code churns while idle
	// ----------------------------------------------------------------
	int cnt = 0;
	always @(negedge clk) begin
		sampleDone <= 1'b0;
		sampleCode <= ~sampleCode;
		if (nrst !== 1'b1) begin
			cnt <= 0;
			sampleCode <= 12'h000;
		end else if (analogConvert !== 1'b1) begin
			cnt <= 0;
		end else if (cnt == delayIn) begin
			cnt <= cnt + 1;
			sampleDone <= 1'b1;
			sampleCode <= codeIn;
		end else if (cnt < delayIn) begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

// ---- test/test_sar_converter_sequencer.sv ----
// Self-checking bench for the converter sequencer.
// Assumes the sampler model and the bound checker compile alongside.
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"

module test_sar_converter_sequencer;
	logic clk = 1'b0, nrst = 1'b0, wrEn = 1'b0, rdEn = 1'b0;
	logic t3 = 1'b0, t2 = 1'b0, pin = 1'b0;
	logic ce = 1'b1;
	logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, ctrlV;
	logic done, win, pwr, trk, cnv, tick, sDone;
	logic [11:0] code = 12'h000, sCode;
	logic [3:0] dly = 4'h1;
	int errors = 0, tests_run = 0, doneCnt = 0, winCnt = 0, smpCnt = 0;
	int trkLen = 0, lastTrk = 0, lat = 0;
	always #5 clk = ~clk;
	sar_converter_sequencer dut_u (.clk(clk), .nrst(nrst), .ce(ce),
		.sfrAddr(addr), .sfrWrEn(wrEn), .sfrWrData(wdat), .sfrRdEn(rdEn),
		.sfrRdData(rdat), .timer3Overflow(t3), .timer2Overflow(t2),
		.externalConvertPin(pin), .sampleDone(sDone), .sampleCode(sCode),
		.analogPowerOn(pwr), .analogTrack(trk), .analogConvert(cnv),
		.sarClockTick(tick), .conversionDoneEvent(done),
		.windowMatchEvent(win));
	sar_sampler smp_u (.clk(clk), .nrst(nrst), .analogConvert(cnv),
		.sampleDone(sDone), .sampleCode(sCode), .delayIn(dly), .codeIn(code));
	// ----------------------------------------------------------------
	// Monitors and tasks
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (done === 1'b1) doneCnt <= doneCnt + 1;
		if (win === 1'b1) winCnt <= winCnt + 1;
		if (sDone === 1'b1 && cnv === 1'b1) smpCnt <= smpCnt + 1;
		if (trk === 1'b1) trkLen <= trkLen + 1;
		else if (trkLen != 0) begin
			lastTrk <= trkLen;
			trkLen <= 0;
		end
	end
	task automatic chk(input string n, input logic [15:0] s, e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(negedge clk);
		addr = a;
		wdat = d;
		wrEn = 1'b1;
		@(negedge clk);
		wrEn = 1'b0;
	endtask
	task automatic rc(input string n, input logic [7:0] a, e);
		@(negedge clk);
		addr = a;
		rdEn = 1'b1;
		@(negedge clk);
		rdEn = 1'b0;
		chk(n, {8'h00, rdat}, {8'h00, e});
	endtask
	task automatic waitCnt(ref int c, input int t);
		int i;
		for (i = 0; i < 3000 && c < t; i++) @(negedge clk);
		if (c < t) begin
			errors++;
			print_verdict();
		end
	endtask
	// Start pulse on the selected source, busy write for source 00
	task automatic trig();
		@(negedge clk);
		t3 = ctrlV[1:0] == `SAR_SRC_TIMER3;
		t2 = ctrlV[1:0] == `SAR_SRC_TIMER2;
		pin = ctrlV[1:0] == `SAR_SRC_PIN;
		@(negedge clk);
		t3 = 1'b0;
		t2 = 1'b0;
		pin = 1'b0;
		if (ctrlV[1:0] == `SAR_SRC_BUSY) wr(`SAR_OFS_CTRL, ctrlV | 8'h10);
	endtask
	// One series of 1, 4, 8 or 16 conversions, then result check
	task automatic series(input logic [1:0] rpt, input logic [11:0] c);
		int n, k, s0, m0;
		logic [15:0] e;
		n = (rpt == 2'h0) ? 1 : (2 << rpt);
		code = c;
		s0 = doneCnt;
		m0 = smpCnt;
		wr(`SAR_OFS_CFG, {5'h01, rpt, 1'b0});
		for (k = 0; k < n; k++) begin
			if (k == 0 || !ctrlV[6]) begin
				trig();
				for (lat = 0; lat < 2000 && trk !== 1'b1 && cnv !== 1'b1;
						lat++) @(negedge clk);
				if (lat >= 2000) begin
					errors++;
					print_verdict();
				end
			end
			waitCnt(smpCnt, m0 + k + 1);
			repeat (3) @(negedge clk);
		end
		chk("doneCount", 16'(doneCnt - s0), 16'h0001);
		e = ctrlV[2] ? {c, 4'h0} : 16'(n * c);
		rc("resHi", `SAR_OFS_RES_HI, e[15:8]);
		rc("resLo", `SAR_OFS_RES_LO, e[7:0]);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int i, s;
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		rc("track", `SAR_OFS_TRACK, `SAR_RST_TRACK);
		rc("cfg", `SAR_OFS_CFG, `SAR_RST_CFG);
		rc("ctrl", `SAR_OFS_CTRL, `SAR_RST_CTRL);
		rc("upHi", `SAR_OFS_UPPER_HI, 8'hff);
		rc("upLo", `SAR_OFS_UPPER_LO, 8'hff);
		rc("lowHi", `SAR_OFS_LOWER_HI, 8'h00);
		rc("resHi", `SAR_OFS_RES_HI, 8'h00);
		rc("unmapped", 8'h00, 8'h00);
		// Clock enable low freezes registers
		ce = 1'b0;
		wr(`SAR_OFS_UPPER_LO, 8'h55);
		ce = 1'b1;
		rc("ceFreeze", `SAR_OFS_UPPER_LO, 8'hff);
		chk("powerOff", 16'(pwr), 16'h0000);
		wr(`SAR_OFS_CFG, 8'h0a);
		rc("cfgBit0", `SAR_OFS_CFG, 8'h0a);
		wr(`SAR_OFS_TRACK, 8'h06);
		// Busy write with timer source, then busy write of 0
		ctrlV = 8'h81;
		wr(`SAR_OFS_CTRL, ctrlV);
		wr(`SAR_OFS_CTRL, 8'h91);
		wr(`SAR_OFS_CTRL, 8'h80);
		wr(`SAR_OFS_CTRL, 8'h80);
		repeat (60) @(negedge clk);
		chk("noStart", 16'(smpCnt), 16'h0000);
		chk("powerOn", 16'(pwr), 16'h0001);
		// Divider field 1: one tick every second cycle
		s = 0;
		repeat (20) begin
			@(negedge clk);
			s += tick;
		end
		chk("tickRate", 16'(s), 16'h000a);
		for (i = 0; i < 4; i++) begin
			ctrlV = 8'h80 | i[7:0];
			wr(`SAR_OFS_CTRL, ctrlV);
			series(2'h0, 12'h5a0 + i[11:0]);
			rc("ctrlFlag", `SAR_OFS_CTRL, ctrlV | 8'h20);
		end
		chk("trackLen", 16'(lastTrk >= 16 && lastTrk <= 18), 16'h0001);
		// Repeat codes, normal then burst, slow sampler
		dly = 4'h9;
		for (i = 0; i < 8; i++) begin
			ctrlV = (i < 4) ? 8'h80 : 8'hc0;
			wr(`SAR_OFS_CTRL, ctrlV);
			series(i[1:0], 12'hfff - i[11:0]);
		end
		wr(`SAR_OFS_CFG, 8'h08);
		ctrlV = 8'h84;
		wr(`SAR_OFS_CTRL, ctrlV);
		series(2'h0, 12'h7ff);
		// Disable during tracking aborts; software clears stale result
		ctrlV = 8'h80;
		wr(`SAR_OFS_CTRL, ctrlV);
		trig();
		wr(`SAR_OFS_CTRL, 8'h00);
		rc("abortCtrl", `SAR_OFS_CTRL, 8'h00);
		wr(`SAR_OFS_CTRL, ctrlV);
		wr(`SAR_OFS_RES_LO, 8'h00);
		wr(`SAR_OFS_RES_HI, 8'h00);
		rc("clrHi", `SAR_OFS_RES_HI, 8'h00);
		rc("clrLo", `SAR_OFS_RES_LO, 8'h00);
		// Window inside then outside
		wr(`SAR_OFS_UPPER_LO, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr(`SAR_OFS_UPPER_HI, i < 2 ? 8'h01 : 8'h02);
			wr(`SAR_OFS_LOWER_HI, i < 2 ? 8'h02 : 8'h01);
			ctrlV = 8'h80;
			wr(`SAR_OFS_CTRL, ctrlV);
			s = winCnt;
			series(2'h0, i[0] ? 12'h180 : 12'h080);
			chk("window", 16'(winCnt - s), 16'(i[0] ^ (i >= 2)));
			repeat (20) @(negedge clk);
			rc("winFlag", `SAR_OFS_CTRL,
				(i[0] ^ (i >= 2)) ? 8'ha8 : 8'ha0);
		end
		// Pre-tracking starts converting at once, no track phase
		wr(`SAR_OFS_TRACK, 8'h0b);
		ctrlV = 8'h80;
		wr(`SAR_OFS_CTRL, ctrlV);
		s = lastTrk;
		series(2'h0, 12'h321);
		chk("preTrack", 16'(lastTrk - s), 16'h0000);
		// Burst from sleep with power-up wait
		wr(`SAR_OFS_TRACK, 8'h15);
		ctrlV = 8'h40;
		wr(`SAR_OFS_CTRL, ctrlV);
		chk("sleep", 16'(pwr), 16'h0000);
		series(2'h1, 12'h123);
		chk("wake", 16'(lat >= 79 && lat <= 82), 16'h0001);
		chk("sleepAgain", 16'(pwr), 16'h0000);
		print_verdict();
	end
endmodule
`default_nettype wire
